// *** sfrp_read_path.sv ***
/*
 * Device-side read instruction path of a serial NOR flash: plain, fast and
 * dual-output array reads, sector lock register read and OTP area read.
 * Assumes the host drives the serial clock and select as asynchronous pins;
 * memory contents are supplied by a combinational lookup on the user side.
 */
// How it works
// - Plain read: 24 address bits on rising
// - Plain read data shifted on falling edge
// - Fast read: address, dummy byte, then data
// - Dual read: address plus dummy byte first
// - Dual read drives two bits per edge
// - Array address increments after every data byte
// - Array address wraps to zero at top
// - Array reads ignore address bits 23-22
// - Select high stops output and instruction
// - Array read rejected while busy
// - Lock read returns addressed sector's lock
// - Lock read rejected while busy
// - Lock-down bit freezes both lock bits
// - Write lock blocks sector modify operations
// - OTP read: address, dummy, incrementing bytes
// - OTP read repeats byte 64 forever
// - OTP read ignores address bits 23-7
// - OTP read rejected while busy
// - Busy flag set during write cycles
`timescale 1ns/1ps
`include "sfrp_defines.svh"
module sfrp_read_path (
  input  wire logic                clock,
  input  wire logic                arst_n,
  input  wire logic                sck,
  input  wire logic                sel_n,
  input  wire logic                data_line_zero_i,
  input  wire logic                data_line_one_i,
  output logic                     data_line_zero_o,
  output logic                     data_line_zero_oe,
  output logic                     data_line_one_o,
  output logic                     data_line_one_oe,
  input  wire logic                write_in_progress_flag,
  output logic [21:0]              mem_addr,
  input  wire logic [7:0]          mem_data,
  output logic [6:0]               otp_addr,
  input  wire logic [7:0]          otp_data,
  input  wire logic [63:0]         lock_wr_en,
  input  wire logic [1:0]          lock_wr_val,
  input  wire logic [5:0]          modify_sector,
  output logic                     modify_allowed,
  output logic                     read_rejected
);
  // ---------------------------------------------------------------
  // Reset and pin synchronisation
  // ---------------------------------------------------------------
  logic       rst_m_r, rst_n_r;
  logic [3:0] pins_s;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  sfrp_sync #(.W(4)) u_sync (
    .clock (clock),
    .rst_n (rst_n_r),
    .d     ({sck, ~sel_n, data_line_zero_i, data_line_one_i}),
    .q     (pins_s)
  );

  logic sck_s, sel_s, din_s;
  assign sck_s = pins_s[3];
  assign sel_s = pins_s[2];
  assign din_s = pins_s[1];

  logic sck_d_r;
  logic rise, fall;
  assign rise = sck_s & ~sck_d_r & sel_s;
  assign fall = ~sck_s & sck_d_r & sel_s;

  // ---------------------------------------------------------------
  // Sector lock bits
  // ---------------------------------------------------------------
  // Volatile: cleared by reset, standing in for power-up; a set lock-down bit clears only on reset
  logic [1:0] lock_r   [64];
  logic [1:0] lock_nxt [64];

  always_comb begin
    for (int s = 0; s < 64; s++) begin
      lock_nxt[s] = lock_r[s];
      if (lock_wr_en[s] && !lock_r[s][`SFRP_LOCK_LDOWN_BIT]) begin
        lock_nxt[s] = lock_wr_val;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int s = 0; s < 64; s++) begin
        lock_r[s] <= 2'h0;
      end
    end else begin
      for (int s = 0; s < 64; s++) begin
        lock_r[s] <= lock_nxt[s];
      end
    end
  end

  assign modify_allowed = ~lock_r[modify_sector][`SFRP_LOCK_WLOCK_BIT];

  // ---------------------------------------------------------------
  // Instruction sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HEAD,
    ST_DATA,
    ST_DEAD
  } sfrp_st_e;

  function automatic logic needs_dummy(sfrp_pkg::sfrp_cmd_e c);
    return (c == sfrp_pkg::SFRP_CMD_FAST) || (c == sfrp_pkg::SFRP_CMD_DUAL) ||
           (c == sfrp_pkg::SFRP_CMD_OTP);
  endfunction

  function automatic sfrp_pkg::sfrp_cmd_e decode(logic [7:0] op);
    unique case (op)
      `SFRP_OP_READ:      return sfrp_pkg::SFRP_CMD_READ;
      `SFRP_OP_FAST_READ: return sfrp_pkg::SFRP_CMD_FAST;
      `SFRP_OP_DUAL_READ: return sfrp_pkg::SFRP_CMD_DUAL;
      `SFRP_OP_LOCK_READ: return sfrp_pkg::SFRP_CMD_LOCK;
      `SFRP_OP_OTP_READ:  return sfrp_pkg::SFRP_CMD_OTP;
      default:            return sfrp_pkg::SFRP_CMD_NONE;
    endcase
  endfunction

  sfrp_st_e            st_r, st_nxt;
  sfrp_pkg::sfrp_cmd_e cmd_r, cmd_nxt;
  logic [5:0]          cnt_r, cnt_nxt;
  logic [23:0]         sh_r, sh_nxt;
  sfrp_pkg::sfrp_rdreq_s req_r, req_nxt;
  logic [7:0]          out_r, out_nxt;
  logic [2:0]          bit_r, bit_nxt;
  logic                rej_r, rej_nxt;
  sfrp_pkg::sfrp_pins_s pins_r, pins_nxt;
  logic [7:0]          cur_byte;

  always_comb begin
    if (req_r.lock) begin
      cur_byte = {6'h00, lock_r[req_r.addr[21:16]]};
    end else if (req_r.otp) begin
      cur_byte = otp_data;
    end else begin
      cur_byte = mem_data;
    end
  end

  always_comb begin
    st_nxt    = st_r;
    cmd_nxt   = cmd_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    req_nxt   = req_r;
    out_nxt   = out_r;
    bit_nxt   = bit_r;
    rej_nxt   = rej_r;
    if (!sel_s) begin
      st_nxt    = ST_IDLE;
      cnt_nxt   = 6'h00;
      cmd_nxt   = sfrp_pkg::SFRP_CMD_NONE;
    end else begin
      unique case (st_r)
        ST_IDLE, ST_HEAD: begin
          st_nxt = ST_HEAD;
          if (rise) begin
            sh_nxt  = {sh_r[22:0], din_s};
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_nxt == `SFRP_OPC_BITS) begin
              cmd_nxt = decode({sh_r[6:0], din_s});
              rej_nxt = 1'b0;
              if (cmd_nxt == sfrp_pkg::SFRP_CMD_NONE) begin
                st_nxt = ST_DEAD;
              end else if (write_in_progress_flag) begin
                st_nxt  = ST_DEAD;
                rej_nxt = 1'b1;
              end
            end
            if (cnt_nxt == `SFRP_ADDR_END) begin
              req_nxt.addr = sh_nxt[`SFRP_ARRAY_AW-1:0];
              req_nxt.dual = (cmd_r == sfrp_pkg::SFRP_CMD_DUAL);
              req_nxt.otp  = (cmd_r == sfrp_pkg::SFRP_CMD_OTP);
              req_nxt.lock = (cmd_r == sfrp_pkg::SFRP_CMD_LOCK);
              if (req_nxt.otp) begin
                req_nxt.addr = {15'h0000, sh_nxt[`SFRP_OTP_AW-1:0]};
              end
            end
            if ((cnt_nxt == `SFRP_ADDR_END && !needs_dummy(cmd_r)) ||
                cnt_nxt == `SFRP_DUMMY_END) begin
              st_nxt = ST_DATA;
              bit_nxt = 3'h0;
            end
          end
        end
        ST_DATA: begin
          if (fall) begin
            if (bit_r == 3'h0) begin
              out_nxt = req_r.dual ? {cur_byte[5:0], 2'b00} : {cur_byte[6:0], 1'b0};
            end else begin
              out_nxt = req_r.dual ? {out_r[5:0], 2'b00} : {out_r[6:0], 1'b0};
            end
            bit_nxt = req_r.dual ? bit_r + 3'h2 : bit_r + 3'h1;
            if (bit_nxt == 3'h0) begin
              if (req_r.otp) begin
                if (req_r.addr[6:0] != `SFRP_OTP_LAST) begin
                  req_nxt.addr = req_r.addr + 22'h000001;
                end
              end else if (!req_r.lock) begin
                req_nxt.addr = req_r.addr + 22'h000001;
              end
            end
          end
        end
        ST_DEAD: begin
          st_nxt = ST_DEAD;
        end
      endcase
    end
  end

  // Output bit chosen at the falling edge from the byte or the shifter
  logic [1:0] tx_bits;
  always_comb begin
    if (bit_r == 3'h0) begin
      tx_bits = req_r.dual ? cur_byte[7:6] : {1'b0, cur_byte[7]};
    end else begin
      tx_bits = req_r.dual ? out_r[7:6] : {1'b0, out_r[7]};
    end
  end

  always_comb begin
    pins_nxt = pins_r;
    if (!sel_s || st_r != ST_DATA) begin
      pins_nxt = '0;
    end else if (fall) begin
      pins_nxt.d1_oe = 1'b1;
      pins_nxt.d0_oe = req_r.dual;
      pins_nxt.d1_o  = req_r.dual ? tx_bits[1] : tx_bits[0];
      pins_nxt.d0_o  = req_r.dual ? tx_bits[0] : 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r    <= ST_IDLE;
      cmd_r   <= sfrp_pkg::SFRP_CMD_NONE;
      cnt_r   <= 6'h00;
      sh_r    <= 24'h000000;
      req_r   <= '0;
      out_r   <= 8'h00;
      bit_r   <= 3'h0;
      rej_r   <= 1'b0;
      pins_r  <= '0;
      sck_d_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cmd_r   <= cmd_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      req_r   <= req_nxt;
      out_r   <= out_nxt;
      bit_r   <= bit_nxt;
      rej_r   <= rej_nxt;
      pins_r  <= pins_nxt;
      sck_d_r <= sck_s;
    end
  end

  assign data_line_zero_o  = pins_r.d0_o;
  assign data_line_zero_oe = pins_r.d0_oe;
  assign data_line_one_o   = pins_r.d1_o;
  assign data_line_one_oe  = pins_r.d1_oe;
  assign mem_addr          = req_r.addr;
  assign otp_addr          = req_r.addr[6:0];
  assign read_rejected     = rej_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence deselect_s;
    !sel_s;
  endsequence

  float_on_desel_a: assert property (@(posedge clock) disable iff (!rst_n_r)
    deselect_s |=> !data_line_one_oe && !data_line_zero_oe)
    else $error("data lines driven after deselect");

  busy_reject_a: assert property (@(posedge clock) disable iff (!rst_n_r)
    (st_r == ST_HEAD && st_nxt == ST_DEAD && cmd_nxt != sfrp_pkg::SFRP_CMD_NONE)
      |=> read_rejected && st_r == ST_DEAD)
    else $error("busy read not rejected");

  dual_pins_a: assert property (@(posedge clock) disable iff (!rst_n_r)
    data_line_zero_oe |-> data_line_one_oe && req_r.dual)
    else $error("line zero driven outside dual read");

  // Watched sector must stay put for the comparison to mean anything
  sequence held_locked_s;
    lock_r[modify_sector][`SFRP_LOCK_LDOWN_BIT] ##1 $stable(modify_sector);
  endsequence

  lock_down_a: assert property (@(posedge clock) disable iff (!rst_n_r)
    held_locked_s |-> $stable(lock_r[modify_sector]))
    else $error("locked-down sector lock changed");

  otp_hold_a: assert property (@(posedge clock) disable iff (!rst_n_r)
    (req_r.otp && req_r.addr[6:0] == `SFRP_OTP_LAST && st_r == ST_DATA) |=> req_r.addr[6:0] == `SFRP_OTP_LAST)
    else $error("otp address left last byte");

  addr_mask_a: assert property (@(posedge clock) disable iff (!rst_n_r)
    req_r.otp |-> req_r.addr[21:7] == 15'h0000)
    else $error("otp address high bits kept");

  write_lock_a: assert property (@(posedge clock) disable iff (!rst_n_r)
    lock_r[modify_sector][`SFRP_LOCK_WLOCK_BIT] |-> !modify_allowed)
    else $error("modify allowed on locked sector");

  idle_float_a: assert property (@(posedge clock) disable iff (!rst_n_r)
    st_r != ST_DATA |=> !data_line_one_oe)
    else $error("line one driven outside data phase");
endmodule

// *** sfrp_defines.svh ***
/*
 * Constants for the serial flash read path: opcodes, phase lengths, address
 * masks and lock register field positions.
 * Assumes inclusion by the main module and the bench only.
 */
`ifndef SFRP_DEFINES_SVH
`define SFRP_DEFINES_SVH

`define SFRP_OP_READ        8'h03
`define SFRP_OP_FAST_READ   8'h0b
`define SFRP_OP_DUAL_READ   8'h3b
`define SFRP_OP_LOCK_READ   8'he8
`define SFRP_OP_OTP_READ    8'h4b
`define SFRP_ADDR_BITS      24
`define SFRP_ARRAY_AW       22
`define SFRP_OTP_AW         7
`define SFRP_OTP_LAST       7'h40
`define SFRP_SECTOR_AW      6
`define SFRP_LOCK_WLOCK_BIT 0
`define SFRP_LOCK_LDOWN_BIT 1
`define SFRP_OPC_BITS       6'h08
`define SFRP_ADDR_END       6'h20
`define SFRP_DUMMY_END      6'h28

`endif

// *** sfrp_pkg.sv ***
/*
 * Types shared by the serial flash read path.
 * Assumes the defines header is compiled alongside.
 */
package sfrp_pkg;
  typedef enum logic [2:0] {
    SFRP_CMD_NONE,
    SFRP_CMD_READ,
    SFRP_CMD_FAST,
    SFRP_CMD_DUAL,
    SFRP_CMD_LOCK,
    SFRP_CMD_OTP
  } sfrp_cmd_e;

  typedef struct packed {
    logic d0_o;
    logic d0_oe;
    logic d1_o;
    logic d1_oe;
  } sfrp_pins_s;

  typedef struct packed {
    logic [21:0] addr;
    logic        dual;
    logic        otp;
    logic        lock;
  } sfrp_rdreq_s;
endpackage

// *** sfrp_sync.sv ***
/*
 * Two-flop synchroniser for the serial link pins.
 * Assumes asynchronous inputs and an active-low synchronised reset.
 */
`timescale 1ns/1ps
module sfrp_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// *** sfrp_host_model.sv ***
/* Host controller model that issues read instructions on the serial link.
   Assumes the bench resolves pin levels onto d0 and d1. */
`timescale 1ns/1ps
module sfrp_host_model (
  output logic       sck,
  output logic       sel_n,
  output logic       mosi,
  input  wire logic  d0,
  input  wire logic  d1,
  output logic [7:0] rx_byte,
  output logic       rx_valid
);
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end
  // --------------------------------------------------------------
  // One framed instruction; sck stands low outside frames
  // --------------------------------------------------------------
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nd, input int nb,
                       input bit dual, input bit rep);
    logic [39:0] h;
    int          n;
    h = {op, a, 8'h00};
    n = 32 + 8 * nd;
    sel_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = h[39-i];
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    for (int i = 0; i < nb; i++) begin
      // Released line must not keep its last level
      mosi = ~mosi;
      #80 sck = 1'b1;
      rx_byte = dual ? {rx_byte[5:0], d1, d0} : {rx_byte[6:0], d1};
      rx_valid = rep && (dual ? i % 4 == 3 : i % 8 == 7);
      #1 rx_valid = 1'b0;
      #79 sck = 1'b0;
    end
    #80 sel_n = 1'b1;
    #160;
  endtask
endmodule

// *** tb_top.sv ***
/* Self-checking bench for the flash read path.
   Assumes the host model drives the link and the bench supplies memory. */
`timescale 1ns/1ps
`include "sfrp_defines.svh"
module tb_top;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        busy = 1'b0;
  logic        quiet = 1'b0;
  logic [63:0] lock_wr_en = 64'h0;
  logic [1:0]  lock_wr_val = 2'h0;
  logic [5:0]  modify_sector = 6'h0;
  logic        sck, sel_n, mosi, o0, oe0, o1, oe1, idle1 = 1'b0;
  logic        modify_allowed, read_rejected, rx_valid;
  logic [21:0] mem_addr;
  logic [6:0]  otp_addr;
  logic [7:0]  rx_byte;
  logic [7:0]  expq[$];
  logic [7:0]  ops[5] = '{`SFRP_OP_READ, `SFRP_OP_FAST_READ, `SFRP_OP_DUAL_READ,
                          `SFRP_OP_LOCK_READ, `SFRP_OP_OTP_READ};
  logic [23:0] ra;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          oe_busy = 0;
  int          seed = 60;

  always #5 clock = ~clock;

  sfrp_read_path u_sfrp_read_path (.clock(clock), .arst_n(arst_n), .sck(sck), .sel_n(sel_n),
    .data_line_zero_i(oe0 ? o0 : mosi), .data_line_one_i(oe1 ? o1 : idle1),
    .data_line_zero_o(o0), .data_line_zero_oe(oe0), .data_line_one_o(o1), .data_line_one_oe(oe1),
    .write_in_progress_flag(busy), .mem_addr(mem_addr), .mem_data(mexp(mem_addr)),
    .otp_addr(otp_addr), .otp_data({1'b0, otp_addr} ^ 8'ha5), .lock_wr_en(lock_wr_en),
    .lock_wr_val(lock_wr_val), .modify_sector(modify_sector), .modify_allowed(modify_allowed),
    .read_rejected(read_rejected));

  sfrp_host_model u_sfrp_host_model (.sck(sck), .sel_n(sel_n), .mosi(mosi),
    .d0(oe0 ? o0 : mosi), .d1(oe1 ? o1 : idle1), .rx_byte(rx_byte), .rx_valid(rx_valid));

  function automatic logic [7:0] mexp(input logic [21:0] a);
    return a[7:0] ^ {2'h0, a[21:16]};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    check({7'h0, expq.size() != 0}, 8'h00);
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic rd(input logic [7:0] op, input int nd, input bit dual, input logic [23:0] a,
                    input int n);
    for (int i = 0; i < n; i++)
      expq.push_back(mexp(a[21:0] + 22'(i)));
    u_sfrp_host_model.frame(op, a, nd, dual ? 4 * n : 8 * n, dual, 1'b1);
  endtask

  task automatic lockw(input int s, input logic [1:0] v);
    @(posedge clock);
    lock_wr_en <= 64'h1 << s;
    lock_wr_val <= v;
    @(posedge clock);
    lock_wr_en <= 64'h0;
    @(posedge clock);
  endtask

  task automatic lrd(input logic [5:0] s, input logic [7:0] v);
    expq.push_back(v);
    u_sfrp_host_model.frame(`SFRP_OP_LOCK_READ, {2'h0, s, 16'($random(seed))}, 0, 8, 1'b0, 1'b1);
  endtask

  task automatic msec(input logic [5:0] s, input logic [7:0] v);
    @(posedge clock);
    modify_sector <= s;
    @(posedge clock);
    #1 check({7'h0, modify_allowed}, v);
  endtask

  // ----------------------------------------------------------------
  // Scoreboard and watchdog
  // ----------------------------------------------------------------
  always @(posedge rx_valid)
    check(rx_byte, expq.size() > 0 ? expq.pop_front() : 8'hxx);

  always @(posedge clock) begin
    // Idle second line toggles so a stale level cannot match
    idle1 <= ~idle1;
    cycles++;
    if ((busy || quiet) && (oe0 || oe1))
      oe_busy++;
    if (cycles == 40000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (6) @(posedge clock);
    ra = {2'b11, 22'($random(seed))};
    rd(`SFRP_OP_READ, 0, 1'b0, ra, 3);
    rd(`SFRP_OP_FAST_READ, 1, 1'b0, 24'h3ffffe, 3);
    rd(`SFRP_OP_DUAL_READ, 1, 1'b1, ra ^ 24'h400000, 3);
    $display("array reads done");
    lockw(5, 2'b01);
    lrd(5, 8'h01);
    msec(6'd5, 8'h00);
    msec(6'd6, 8'h01);
    lockw(5, 2'b11);
    msec(6'd5, 8'h00);
    lockw(5, 2'b00);
    lrd(5, 8'h03);
    $display("lock reads done");
    for (int i = 0; i < 5; i++)
      expq.push_back({1'b0, i < 2 ? 7'h3e + 7'(i) : 7'h40} ^ 8'ha5);
    u_sfrp_host_model.frame(`SFRP_OP_OTP_READ, 24'hffffbe, 1, 40, 1'b0, 1'b1);
    $display("otp read done");
    @(posedge clock);
    busy <= 1'b1;
    foreach (ops[i]) begin
      u_sfrp_host_model.frame(ops[i], ra, 1, 8, 1'b0, 1'b0);
      check({7'h0, read_rejected}, 8'h01);
    end
    check({7'h0, oe_busy != 0}, 8'h00);
    @(posedge clock);
    busy <= 1'b0;
    quiet <= 1'b1;
    // Unknown opcode must leave the lines floating and clear the reject flag
    u_sfrp_host_model.frame(8'h00, ra, 0, 8, 1'b0, 1'b0);
    check({7'h0, read_rejected}, 8'h00);
    check({7'h0, oe_busy != 0}, 8'h00);
    @(posedge clock);
    quiet <= 1'b0;
    $display("busy rejection done");
    u_sfrp_host_model.frame(`SFRP_OP_READ, ra, 0, 4, 1'b0, 1'b0);
    check({6'h0, oe1, oe0}, 8'h00);
    rd(`SFRP_OP_READ, 0, 1'b0, ra, 1);
    $display("abort done");
    report_and_stop();
  end
endmodule
